/* sfp_pkg.sv */
// constants and types shared by the serial flash pin front end
// assumes: core clock at 10 MHz, host link clock unrelated to it
package sfp_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SYNC_W = 3;
  localparam int RESTART_PULSE_MIN_NS = 1000;
  localparam int RESTART_CYCLES =
    (RESTART_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESTART_W = $clog2(RESTART_CYCLES + 1);
  localparam int PAGE_PROG_US = 350;
  localparam int SECTOR_ERASE_US = 25000;
  localparam int BLOCK_ERASE_US = 250000;
  localparam int CHIP_ERASE_US = 2000000;
  localparam int TIMER_W = 25;
  localparam int ADDR_W = 19;
  localparam int ARRAY_BYTES = 524288;
  localparam int PAGE_BYTES = 256;
  localparam int PAGE_COUNT = 2048;
  localparam int SECTOR_BYTES = 4096;
  localparam int SECTOR_COUNT = 128;
  localparam int BLOCK_BYTES = 65536;
  localparam int BLOCK_COUNT = 8;
  localparam int PAGE_LSB = 8;
  localparam int SECTOR_LSB = 12;
  localparam int BLOCK_LSB = 16;
  localparam int PROTECT_MAX_SHIFT = 3;

  function automatic int usToCycles(input int us);
    return us * (1000 / CLK_PERIOD_NS);
  endfunction

  localparam int PAGE_PROG_CYCLES = usToCycles(PAGE_PROG_US);

  typedef enum logic [1:0] {
    LANES_ONE = 2'h0,
    LANES_TWO = 2'h1,
    LANES_FOUR = 2'h2
  } sfp_width_t;

  typedef enum logic [2:0] {
    OP_PAGE_PROGRAM = 3'h0,
    OP_SECTOR_ERASE = 3'h1,
    OP_BLOCK_ERASE = 3'h2,
    OP_CHIP_ERASE = 3'h3,
    OP_STATUS_WRITE = 3'h4
  } sfp_op_t;

  typedef enum logic {
    ST_IDLE = 1'h0,
    ST_BUSY = 1'h1
  } sfp_state_t;
endpackage

/* sfp_link_if.sv */
// signals between the core logic and the host-clocked lane logic
// assumes: core drives config and tx byte as slow, settled levels
`timescale 1ns/1ps
interface sfp_link_if;
  sfp_pkg::sfp_width_t width;
  logic driveOut;
  logic pauseEnable;
  logic abortLink;
  logic [7:0] txByte;
  logic txTakeToggle;
  logic [7:0] rxByte;
  logic rxToggle;
  logic selectArmed;
  modport core (
    output width, driveOut, pauseEnable, abortLink, txByte,
    input txTakeToggle, rxByte, rxToggle, selectArmed
  );
  modport link (
    input width, driveOut, pauseEnable, abortLink, txByte,
    output txTakeToggle, rxByte, rxToggle, selectArmed
  );
endinterface

/* sfp_link.sv */
// host-clocked lane logic: bytes in on rising sclk, out on falling sclk
// assumes: csN and lanes come straight from the host pins
`timescale 1ns/1ps
module sfp_link (
  // link pins
  input wire logic sclk,
  input wire logic csN,
  input wire logic resetn,
  input wire logic [3:0] laneIn,
  output logic [3:0] laneOut,
  output logic [3:0] laneOe,
  // core side
  sfp_link_if.link lnk
);
  typedef struct packed {
    logic [7:0] shift;
    logic [2:0] count;
    logic [7:0] out;
  } sfp_shift_t;
  typedef struct packed {
    logic [7:0] data;
    logic rxToggle;
  } sfp_event_t;

  sfp_shift_t rx_reg, rx_next, tx_reg, tx_next;
  sfp_event_t ev_reg, ev_next;
  logic take_reg, take_next;
  logic armed_reg;
  logic linkRst, armRst, paused;
  logic [2:0] step;
  logic [7:0] txCur;

  // async: lanes float as soon as cs rises
  assign linkRst = !resetn || csN || lnk.abortLink; // RL4
  assign armRst = !resetn || lnk.abortLink;
  assign paused = lnk.pauseEnable && !laneIn[3]; // RL9
  assign step = lnk.width == sfp_pkg::LANES_FOUR ? 3'h4 :
    (lnk.width == sfp_pkg::LANES_TWO ? 3'h2 : 3'h1); // RL19
  assign txCur = tx_reg.count == 3'h0 ? lnk.txByte : tx_reg.shift;

  always_comb
  begin
    rx_next = rx_reg;
    ev_next = ev_reg;
    // frozen while paused, so the byte resumes
    if (armed_reg && !paused) // RL6 RL9
    begin
      case (lnk.width)
        sfp_pkg::LANES_TWO:
          rx_next.shift = {rx_reg.shift[5:0], laneIn[1:0]}; // RL3
        sfp_pkg::LANES_FOUR:
          rx_next.shift = {rx_reg.shift[3:0], laneIn}; // RL8 RL10
        default:
          rx_next.shift = {rx_reg.shift[6:0], laneIn[0]}; // RL1
      endcase
      rx_next.count = rx_reg.count + step;
      if (rx_next.count == 3'h0)
      begin
        ev_next.data = rx_next.shift;
        ev_next.rxToggle = !ev_reg.rxToggle;
      end
    end
  end

  always_comb
  begin
    tx_next = tx_reg;
    take_next = take_reg;
    tx_next.out = 8'h00;
    if (lnk.driveOut && !paused) // RL9 RL20
    begin
      if (tx_reg.count == 3'h0)
        take_next = !take_reg;
      case (lnk.width)
        sfp_pkg::LANES_TWO:
          tx_next.out = {2'h0, 2'h3, 2'h0, txCur[7:6]}; // RL3
        sfp_pkg::LANES_FOUR:
          tx_next.out = {4'hF, txCur[7:4]}; // RL8 RL10
        default:
          tx_next.out = {4'h2, 2'h0, txCur[7], 1'b0}; // RL2
      endcase
      tx_next.shift = txCur << step;
      tx_next.count = tx_reg.count + step;
    end
  end

  always_ff @(posedge sclk or posedge linkRst)
  begin
    if (linkRst)
      rx_reg <= '0;
    else
      rx_reg <= rx_next;
  end

  // survives deselect: no false toggle
  always_ff @(posedge sclk or negedge resetn)
  begin
    if (!resetn)
      ev_reg <= '0;
    else
      ev_reg <= ev_next;
  end

  always_ff @(negedge sclk or posedge linkRst)
  begin
    if (linkRst)
      tx_reg <= '0; // RL4 RL20
    else
      tx_reg <= tx_next; // RL2
  end

  always_ff @(negedge sclk or negedge resetn)
  begin
    if (!resetn)
      take_reg <= 1'b0;
    else
      take_reg <= take_next;
  end

  // only a real fall arms; cs low from power-up never does
  always_ff @(negedge csN or posedge armRst)
  begin
    if (armRst)
      armed_reg <= 1'b0;
    else
      armed_reg <= 1'b1; // RL6
  end

  assign laneOut = tx_reg.out[3:0];
  assign laneOe = tx_reg.out[7:4];
  assign lnk.rxByte = ev_reg.data;
  assign lnk.rxToggle = ev_reg.rxToggle;
  assign lnk.txTakeToggle = take_reg;
  assign lnk.selectArmed = armed_reg;
endmodule // sfp_link

/* sfp_flash_front.sv */
// serial flash pin front end
// lane logic, pins, op timer, geometry
// assumes: clk at 10 MHz; sclk, csN and lanes straight from host pins
// What this block does
// RL1: rising sclk samples lane 0.
// RL2: outgoing bits change on the falling sclk edge.
// RL3: dual and quad make lanes 0 and 1 two-way.
// RL4: cs high deselects and floats every output lane.
// RL5: running operations survive deselect.
// RL6: no input until cs falls after power-up.
// RL7: write guard blocks status writes; protect bits guard array.
// RL8: quad mode drops the guard; pin is lane 2.
// RL9: pause while selected floats output and freezes shifting.
// RL10: four-lane enable drops pause; pin is lane 3.
// RL11: restart input works only when lane3 role select is one.
// RL12: restart low for at least 1 us aborts any operation.
// RL13: without four-lane enable, lane 3 pin is pause or restart.
// RL14: array holds 524288 bytes as 2048 pages of 256 bytes.
// RL15: eight 64 KB blocks, 128 sectors of 4 KB.
// RL16: programming only clears bits; erase sets them.
// RL17: sector, block and chip erase exist; no page erase.
// RL18: sectors span aligned 4 KB ranges.
// RL19: single, dual and quad widths share clock and select.
// RL20: undriven lanes float.
`timescale 1ns/1ps
module sfp_flash_front #(
  parameter int SECTOR_ERASE_CYCLES =
    sfp_pkg::usToCycles(sfp_pkg::SECTOR_ERASE_US),
  parameter int BLOCK_ERASE_CYCLES =
    sfp_pkg::usToCycles(sfp_pkg::BLOCK_ERASE_US),
  parameter int CHIP_ERASE_CYCLES =
    sfp_pkg::usToCycles(sfp_pkg::CHIP_ERASE_US),
  parameter int STATUS_WRITE_CYCLES = 100
) (
  // core clock and reset
  input wire logic clk,
  input wire logic resetn,
  // host link
  input wire logic sclk,
  input wire logic csN,
  input wire logic [3:0] laneIn,
  output logic [3:0] laneOut,
  output logic [3:0] laneOe,
  // configuration from the status logic
  input wire logic fourLaneEnable,
  input wire logic lane3RoleSelect,
  input wire logic configLockMode,
  input wire logic [2:0] regionProtectBits,
  input wire logic topOrBottomSelect,
  input wire logic smallUnitProtect,
  input wire logic invertProtectRegion,
  // transfer shape from the command decoder
  input wire sfp_pkg::sfp_width_t width,
  input wire logic driveOut,
  // byte stream
  input wire logic [7:0] txByte,
  output logic txTaken,
  output logic [7:0] rxByte,
  output logic rxValid,
  // background operations
  input wire logic opStart,
  input wire sfp_pkg::sfp_op_t opKind,
  input wire logic [sfp_pkg::ADDR_W-1:0] opAddr,
  output logic opBusy,
  output logic opDone,
  output logic opRefused,
  output logic [sfp_pkg::ADDR_W-1:0] opBase,
  output logic [sfp_pkg::ADDR_W-1:0] opLast,
  // program merge
  input wire logic [7:0] pageOld,
  input wire logic [7:0] pageNew,
  output logic [7:0] pageMerged,
  // status
  output logic statusWriteBlocked,
  output logic selectArmed,
  output logic restartSeen
);
  localparam int AW = sfp_pkg::ADDR_W;
  localparam int SW = sfp_pkg::SYNC_W;
  localparam int TW = sfp_pkg::TIMER_W;
  localparam logic [sfp_pkg::RESTART_W-1:0] RESTART_LAST =
    sfp_pkg::RESTART_W'(sfp_pkg::RESTART_CYCLES - 1);
  localparam logic [AW:0] ARRAY_SIZE = (AW + 1)'(sfp_pkg::ARRAY_BYTES);
  localparam logic [AW-1:0] ARRAY_END = AW'(sfp_pkg::ARRAY_BYTES - 1);

  typedef struct packed {
    logic [SW-1:0] wpSync;
    logic wpLevel;
    logic [SW-1:0] rstSync;
    logic rstLevel;
    logic [SW-1:0] rxSync;
    logic rxLevel;
    logic [SW-1:0] takeSync;
    logic takeLevel;
    logic [SW-1:0] armSync;
    logic armLevel;
    logic [sfp_pkg::RESTART_W-1:0] restartCount;
    logic abortLink;
    logic restartSeen;
    sfp_pkg::sfp_width_t width;
    logic driveOut;
    logic pauseEnable;
    logic [7:0] txByte;
    logic txTaken;
    logic [7:0] rxByte;
    logic rxValid;
    sfp_pkg::sfp_state_t state;
    logic busy;
    logic [TW-1:0] timer;
    logic [AW-1:0] opBase;
    logic [AW-1:0] opLast;
    logic opDone;
    logic opRefused;
    logic [7:0] pageMerged;
    logic statusWriteBlocked;
  } sfp_core_t;

  sfp_core_t s_reg, s_next;
  logic restartEnable;
  logic guardActive;

  sfp_link_if lnk ();

  sfp_link u_link (
    .sclk(sclk),
    .csN(csN),
    .resetn(resetn),
    .laneIn(laneIn),
    .laneOut(laneOut),
    .laneOe(laneOe),
    .lnk(lnk.link)
  );

  // a change counts only once the second and third stages agree
  function automatic logic settle(
    input logic [SW-1:0] s,
    input logic prev
  );
    return (s[1] == s[2]) ? s[1] : prev;
  endfunction

  function automatic logic [SW-1:0] shiftIn(
    input logic [SW-1:0] s,
    input logic pin
  );
    return {s[SW-2:0], pin};
  endfunction

  function automatic logic [AW-1:0] alignDown(
    input logic [AW-1:0] addr,
    input int lsb
  );
    logic [AW-1:0] mask;
    mask = ~((AW'(1) << lsb) - AW'(1));
    return addr & mask;
  endfunction

  // bp selects a power-of-two region of at most eight units: the whole array in blocks, 32 KB in sectors
  function automatic logic protectHit(input logic [AW-1:0] addr);
    logic [AW:0] size;
    logic [2:0] sh;
    logic hit;
    sh = regionProtectBits - 3'h1;
    if (sh > 3'(sfp_pkg::PROTECT_MAX_SHIFT))
      sh = 3'(sfp_pkg::PROTECT_MAX_SHIFT);
    if (smallUnitProtect)
      size = (AW + 1)'(sfp_pkg::SECTOR_BYTES) << sh;
    else
      size = (AW + 1)'(sfp_pkg::BLOCK_BYTES) << sh;
    if (regionProtectBits == 3'h0)
      hit = 1'b0;
    else if (size >= ARRAY_SIZE)
      hit = 1'b1;
    else if (topOrBottomSelect)
      hit = {1'b0, addr} < size;
    else
      hit = {1'b0, addr} >= ARRAY_SIZE - size;
    return hit ^ invertProtectRegion; // RL7
  endfunction

  function automatic logic [TW-1:0] durationOf(input sfp_pkg::sfp_op_t k);
    case (k)
      sfp_pkg::OP_PAGE_PROGRAM: return TW'(sfp_pkg::PAGE_PROG_CYCLES);
      sfp_pkg::OP_SECTOR_ERASE: return TW'(SECTOR_ERASE_CYCLES);
      sfp_pkg::OP_BLOCK_ERASE: return TW'(BLOCK_ERASE_CYCLES);
      sfp_pkg::OP_CHIP_ERASE: return TW'(CHIP_ERASE_CYCLES);
      default: return TW'(STATUS_WRITE_CYCLES);
    endcase
  endfunction

  always_comb
  begin
    s_next = s_reg;
    s_next.wpSync = shiftIn(s_reg.wpSync, laneIn[2]);
    s_next.rstSync = shiftIn(s_reg.rstSync, laneIn[3]);
    s_next.rxSync = shiftIn(s_reg.rxSync, lnk.rxToggle);
    s_next.takeSync = shiftIn(s_reg.takeSync, lnk.txTakeToggle);
    s_next.armSync = shiftIn(s_reg.armSync, lnk.selectArmed);
    s_next.wpLevel = settle(s_reg.wpSync, s_reg.wpLevel);
    s_next.rstLevel = settle(s_reg.rstSync, s_reg.rstLevel);
    s_next.rxLevel = settle(s_reg.rxSync, s_reg.rxLevel);
    s_next.takeLevel = settle(s_reg.takeSync, s_reg.takeLevel);
    s_next.armLevel = settle(s_reg.armSync, s_reg.armLevel);

    // lane role and transfer shape toward the lane logic
    s_next.width = width; // RL19
    s_next.driveOut = driveOut; // RL20
    s_next.pauseEnable = !fourLaneEnable && !lane3RoleSelect; // RL10 RL13
    s_next.txByte = txByte;

    // byte events from the link domain
    s_next.rxValid = 1'b0;
    s_next.txTaken = 1'b0;
    if (s_next.rxLevel != s_reg.rxLevel)
    begin
      s_next.rxValid = 1'b1;
      s_next.rxByte = lnk.rxByte; // RL1
    end
    if (s_next.takeLevel != s_reg.takeLevel)
      s_next.txTaken = 1'b1;

    // write guard is a plain pin function outside quad mode
    guardActive = !fourLaneEnable && configLockMode && !s_reg.wpLevel; // RL8
    s_next.statusWriteBlocked = guardActive; // RL7

    // programming ands new data into old: bits only fall
    s_next.pageMerged = pageOld & pageNew; // RL16

    s_next.opDone = 1'b0;
    s_next.opRefused = 1'b0;
    case (s_reg.state)
      sfp_pkg::ST_IDLE:
      begin
        if (opStart)
        begin
          case (opKind)
            sfp_pkg::OP_PAGE_PROGRAM:
            begin
              s_next.opBase = alignDown(opAddr, sfp_pkg::PAGE_LSB); // RL14
              s_next.opRefused = protectHit(opAddr); // RL7
            end
            sfp_pkg::OP_SECTOR_ERASE:
            begin
              s_next.opBase = alignDown(opAddr, sfp_pkg::SECTOR_LSB); // RL18
              s_next.opRefused = protectHit(opAddr); // RL7
            end
            sfp_pkg::OP_BLOCK_ERASE:
            begin
              s_next.opBase = alignDown(opAddr, sfp_pkg::BLOCK_LSB); // RL15
              s_next.opRefused = protectHit(opAddr); // RL7
            end
            sfp_pkg::OP_CHIP_ERASE:
            begin
              s_next.opBase = AW'(0);
              s_next.opRefused = regionProtectBits != 3'h0 ||
                invertProtectRegion; // RL7 RL17
            end
            sfp_pkg::OP_STATUS_WRITE:
            begin
              s_next.opBase = AW'(0);
              s_next.opRefused = guardActive; // RL7
            end
            default:
            begin
              // no page-sized erase or other kind exists
              s_next.opBase = AW'(0);
              s_next.opRefused = 1'b1; // RL17
            end
          endcase
          case (opKind)
            sfp_pkg::OP_PAGE_PROGRAM:
              s_next.opLast = s_next.opBase |
                AW'(sfp_pkg::PAGE_BYTES - 1); // RL14
            sfp_pkg::OP_SECTOR_ERASE:
              s_next.opLast = s_next.opBase |
                AW'(sfp_pkg::SECTOR_BYTES - 1); // RL18
            sfp_pkg::OP_BLOCK_ERASE:
              s_next.opLast = s_next.opBase |
                AW'(sfp_pkg::BLOCK_BYTES - 1); // RL15
            sfp_pkg::OP_CHIP_ERASE:
              s_next.opLast = ARRAY_END; // RL14
            default:
              s_next.opLast = AW'(0);
          endcase
          if (!s_next.opRefused)
          begin
            s_next.state = sfp_pkg::ST_BUSY;
            s_next.busy = 1'b1;
            s_next.timer = durationOf(opKind) - TW'(1);
          end
        end
      end
      sfp_pkg::ST_BUSY:
      begin
        // no select term here: the cycle runs on through deselect
        if (s_reg.timer == TW'(0)) // RL5
        begin
          s_next.state = sfp_pkg::ST_IDLE;
          s_next.busy = 1'b0;
          s_next.opDone = 1'b1;
        end
        else
          s_next.timer = s_reg.timer - TW'(1); // RL5
      end
      default:
      begin
        s_next.state = sfp_pkg::ST_IDLE;
        s_next.busy = 1'b0;
      end
    endcase

    // restart pin: only in its role and outside quad mode
    restartEnable = lane3RoleSelect && !fourLaneEnable; // RL11 RL13
    s_next.restartSeen = 1'b0;
    if (restartEnable && !s_reg.rstLevel)
    begin
      if (s_reg.restartCount != RESTART_LAST)
        s_next.restartCount = s_reg.restartCount + 1'b1;
      else if (!s_reg.abortLink)
      begin
        // abort wins over any request or completion this cycle
        s_next.abortLink = 1'b1; // RL12
        s_next.restartSeen = 1'b1;
        s_next.state = sfp_pkg::ST_IDLE; // RL12
        s_next.busy = 1'b0;
        s_next.opDone = 1'b0;
        s_next.timer = TW'(0);
      end
    end
    else
    begin
      s_next.restartCount = '0;
      s_next.abortLink = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign lnk.width = s_reg.width;
  assign lnk.driveOut = s_reg.driveOut;
  assign lnk.pauseEnable = s_reg.pauseEnable;
  assign lnk.abortLink = s_reg.abortLink;
  assign lnk.txByte = s_reg.txByte;

  assign txTaken = s_reg.txTaken;
  assign rxByte = s_reg.rxByte;
  assign rxValid = s_reg.rxValid;
  assign opBusy = s_reg.busy;
  assign opDone = s_reg.opDone;
  assign opRefused = s_reg.opRefused;
  assign opBase = s_reg.opBase;
  assign opLast = s_reg.opLast;
  assign pageMerged = s_reg.pageMerged;
  assign statusWriteBlocked = s_reg.statusWriteBlocked;
  assign selectArmed = s_reg.armLevel;
  assign restartSeen = s_reg.restartSeen;
endmodule // sfp_flash_front

/* sfp_host_model.sv */
// host controller model, mode 0, one lane each way
// assumes: bench resolves the lanes
`timescale 1ns/1ps
module sfp_host_model (
  // link outputs
  output logic sclk,
  output logic csN,
  output logic mosi,
  output logic mosiOe,
  // device answer
  input wire logic miso
);
  logic [15:0] rxBits;
  initial
  begin
    sclk = 1'b0;
    // held low from power-up: no fall seen yet
    csN = 1'b0;
    mosi = 1'b0;
    mosiOe = 1'b0;
    rxBits = 16'h0000;
  end
  // sclk only runs inside these calls
  task automatic clockBits(input int n, input logic [15:0] tx);
    for (int i = n - 1; i >= 0; i--)
    begin
      mosi = tx[i];
      mosiOe = 1'b1;
      #7.5 sclk = 1'b1;
      rxBits = {rxBits[14:0], miso};
      #7.5 sclk = 1'b0;
    end
    mosiOe = 1'b0;
  endtask
  task automatic deselect();
    csN = 1'b1;
    #15;
  endtask
  task automatic frame(input int n, input logic [15:0] tx);
    csN = 1'b0;
    #15 clockBits(n, tx);
    #15 deselect();
  endtask
endmodule // sfp_host_model

/* sfp_front_asserts.sv */
// port checker for the front end
// assumes: bound into the top, counts from the bind
`timescale 1ns/1ps
module sfp_front_asserts #(
  parameter int SECTOR_ERASE_CYCLES = 20,
  parameter int BLOCK_ERASE_CYCLES = 30,
  parameter int CHIP_ERASE_CYCLES = 40,
  parameter int STATUS_WRITE_CYCLES = 100
) (
  // pins and config
  input wire logic clk,
  input wire logic resetn,
  input wire logic csN,
  input wire logic [3:0] laneIn,
  input wire logic [3:0] laneOe,
  input wire logic fourLaneEnable,
  input wire logic lane3RoleSelect,
  // operations
  input wire logic opStart,
  input wire sfp_pkg::sfp_op_t opKind,
  input wire logic [sfp_pkg::ADDR_W-1:0] opAddr,
  input wire logic opBusy,
  input wire logic opDone,
  input wire logic opRefused,
  input wire logic [sfp_pkg::ADDR_W-1:0] opBase,
  input wire logic [sfp_pkg::ADDR_W-1:0] opLast,
  input wire logic [7:0] pageOld,
  input wire logic [7:0] pageNew,
  input wire logic [7:0] pageMerged,
  // status
  input wire logic statusWriteBlocked,
  input wire logic selectArmed,
  input wire logic restartSeen,
  input wire logic rxValid
);
  logic [11:0] busyCnt;
  logic [4:0] lowCnt;
  logic [18:0] addrReg;
  sfp_pkg::sfp_op_t kindReg;
  int durNow;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busyCnt <= 12'h000;
      lowCnt <= 5'h00;
      addrReg <= 19'h00000;
      kindReg <= sfp_pkg::OP_PAGE_PROGRAM;
    end
    else
    begin
      busyCnt <= opBusy ? busyCnt + 12'h001 : 12'h000;
      // saturates so a long low never wraps back under the bound
      if (laneIn[3])
        lowCnt <= 5'h00;
      else if (lowCnt != 5'h1F)
        lowCnt <= lowCnt + 5'h01;
      if (opStart && !opBusy)
      begin
        kindReg <= opKind;
        addrReg <= opAddr;
      end
    end
  end
  always_comb
  begin
    case (kindReg)
      sfp_pkg::OP_SECTOR_ERASE: durNow = SECTOR_ERASE_CYCLES;
      sfp_pkg::OP_BLOCK_ERASE: durNow = BLOCK_ERASE_CYCLES;
      sfp_pkg::OP_CHIP_ERASE: durNow = CHIP_ERASE_CYCLES;
      sfp_pkg::OP_STATUS_WRITE: durNow = STATUS_WRITE_CYCLES;
      default: durNow = sfp_pkg::PAGE_PROG_CYCLES;
    endcase
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  chk_deselect_float:
    assert property (csN && $past(csN) |-> laneOe == 4'h0)
    else $error("lane driven while deselected");
  chk_merge_clears:
    assert property ($past(resetn) |=>
      pageMerged == ($past(pageOld) & $past(pageNew)))
    else $error("program merge set a bit");
  chk_sector_range:
    assert property ($rose(opBusy) && kindReg == sfp_pkg::OP_SECTOR_ERASE
      |-> opBase == {addrReg[18:12], 12'h000}
      && opLast == {addrReg[18:12], 12'hFFF})
    else $error("sector range not aligned");
  chk_block_range:
    assert property ($rose(opBusy) && kindReg == sfp_pkg::OP_BLOCK_ERASE
      |-> opBase == {addrReg[18:16], 16'h0000}
      && opLast == {addrReg[18:16], 16'hFFFF})
    else $error("block range not aligned");
  chk_op_duration:
    assert property (opDone |-> !opBusy && int'(busyCnt) == durNow)
    else $error("operation length wrong");
  chk_refuse_unknown:
    assert property (opStart && !opBusy && opKind > sfp_pkg::OP_STATUS_WRITE
      |=> opRefused && !opBusy)
    else $error("unknown operation accepted");
  chk_guard_refuses:
    assert property (opStart && !opBusy && statusWriteBlocked
      && opKind == sfp_pkg::OP_STATUS_WRITE |=> opRefused)
    else $error("guarded status write accepted");
  chk_quad_no_guard:
    assert property (fourLaneEnable [*8] |-> !statusWriteBlocked)
    else $error("guard active in quad mode");
  chk_restart_cause:
    assert property (restartSeen
      |-> lane3RoleSelect && !fourLaneEnable && lowCnt >= 5'h0A)
    else $error("unqualified restart");
  chk_rx_armed:
    assert property (rxValid |-> selectArmed)
    else $error("byte before cs fell");
endmodule // sfp_front_asserts

bind sfp_flash_front sfp_front_asserts #(
  .SECTOR_ERASE_CYCLES(SECTOR_ERASE_CYCLES),
  .BLOCK_ERASE_CYCLES(BLOCK_ERASE_CYCLES),
  .CHIP_ERASE_CYCLES(CHIP_ERASE_CYCLES),
  .STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)
) u_chk (.*);

/* testbench.sv */
// self-checking bench for the flash pin front end
// assumes: host model owns sclk and csN
`timescale 1ns/1ps
module testbench;
  localparam int SEC_N = 20;
  localparam int BLK_N = 30;
  localparam int CHIP_N = 40;
  localparam int STAT_N = 100;
  logic clk = 1'b0, resetn = 1'b0, tgl = 1'b0;
  logic guardN = 1'b1, restartN = 1'b1, fourLaneEnable = 1'b0;
  logic lane3RoleSelect = 1'b0, configLockMode = 1'b0;
  logic [2:0] regionProtectBits = 3'h0;
  logic topOrBottomSelect = 1'b0, smallUnitProtect = 1'b0;
  logic invertProtectRegion = 1'b0, driveOut = 1'b0, opStart = 1'b0;
  sfp_pkg::sfp_width_t width = sfp_pkg::LANES_ONE;
  sfp_pkg::sfp_op_t opKind = sfp_pkg::OP_PAGE_PROGRAM;
  logic [18:0] opAddr = 19'h00000;
  logic [7:0] txByte = 8'h00, pageOld = 8'h00, pageNew = 8'h00;
  logic sclk, csN, mosi, mosiOe, txTaken, rxValid, opBusy, opDone;
  logic opRefused, statusWriteBlocked, selectArmed, restartSeen;
  logic [3:0] laneIn, laneOut, laneOe;
  logic [7:0] rxByte, pageMerged;
  logic [18:0] opBase, opLast;
  int failures = 0, samplesChecked = 0, restarts = 0, rxCount = 0;
  always #50 clk = ~clk;
  // released lines wander so a stale value cannot pass
  always @(posedge clk) tgl <= ~tgl;
  always @(posedge clk)
  begin
    if (restartSeen === 1'b1)
      restarts++;
    if (rxValid === 1'b1)
      rxCount++;
  end
  assign laneIn = (laneOe & laneOut)
    | (~laneOe & {restartN, guardN, tgl, mosiOe ? mosi : tgl});
  sfp_flash_front #(
    .SECTOR_ERASE_CYCLES(SEC_N), .BLOCK_ERASE_CYCLES(BLK_N),
    .CHIP_ERASE_CYCLES(CHIP_N), .STATUS_WRITE_CYCLES(STAT_N)
  ) dut (.*);
  sfp_host_model host (.sclk, .csN, .mosi, .mosiOe, .miso(laneIn[1]));
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [18:0] exp,
    input logic [18:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic waitFlag(input int sel, input int lim);
    int n;
    for (n = 0; n < lim; n++)
    begin
      @(posedge clk);
      #1;
      if ((sel == 0 ? rxValid : sel == 1 ? opDone : restartSeen) === 1'b1)
        break;
    end
    if (n == lim)
    begin
      failures++;
      $display("unexpected wait %0d: expected pulse, seen none", sel);
      end_of_test();
    end
  endtask
  task automatic opReq(input logic [2:0] k, input logic [18:0] a);
    @(posedge clk);
    opStart <= 1'b1;
    opKind <= sfp_pkg::sfp_op_t'(k);
    opAddr <= a;
    @(posedge clk);
    opStart <= 1'b0;
    #1;
  endtask
  task automatic opRun(input logic [2:0] k, input logic [18:0] a,
    input logic [18:0] b, input logic [18:0] l, input int n);
    opReq(k, a);
    check("busy", 19'h1, {18'h0, opBusy});
    check("base", b, opBase);
    check("last", l, opLast);
    // select activity must not disturb the running operation
    host.frame(8, 16'h0011);
    waitFlag(1, n + 5);
    check("busy end", 19'h0, {18'h0, opBusy});
  endtask
  task automatic opRefuse(input logic [2:0] k);
    opReq(k, 19'h01000);
    check("refused", 19'h1, {18'h0, opRefused});
    check("busy on refuse", 19'h0, {18'h0, opBusy});
  endtask
  task automatic sWrite(input logic [7:0] b);
    host.frame(8, {8'h00, b});
    waitFlag(0, 12);
    check("rx byte", {11'h0, b}, {11'h0, rxByte});
    check("armed", 19'h1, {18'h0, selectArmed});
  endtask
  task automatic sRead();
    @(posedge clk);
    driveOut <= 1'b1;
    txByte <= 8'h96;
    repeat (3) @(posedge clk);
    // first falling edge loads the byte, so one extra clock
    host.frame(9, 16'h0000);
    check("read", 19'h96, {11'h0, host.rxBits[7:0]});
    check("lanes idle", 19'h0, {15'h0, laneOe});
    @(posedge clk);
    driveOut <= 1'b0;
  endtask
  task automatic sGuard();
    @(posedge clk);
    configLockMode <= 1'b1;
    guardN <= 1'b0;
    repeat (8) @(posedge clk);
    check("guard", 19'h1, {18'h0, statusWriteBlocked});
    opRefuse(3'h4);
    fourLaneEnable <= 1'b1;
    repeat (8) @(posedge clk);
    check("quad guard", 19'h0, {18'h0, statusWriteBlocked});
    opReq(3'h4, 19'h0);
    check("status busy", 19'h1, {18'h0, opBusy});
    waitFlag(1, STAT_N + 5);
    fourLaneEnable <= 1'b0;
    configLockMode <= 1'b0;
    guardN <= 1'b1;
  endtask
  task automatic sRestart();
    opReq(3'h1, 19'h02000);
    restartN <= 1'b0;
    repeat (15) @(posedge clk);
    restartN <= 1'b1;
    check("pause role", 19'h0, 19'(restarts));
    waitFlag(1, SEC_N);
    @(posedge clk);
    lane3RoleSelect <= 1'b1;
    opReq(3'h1, 19'h02000);
    restartN <= 1'b0;
    waitFlag(2, 20);
    check("restart busy", 19'h0, {18'h0, opBusy});
    restartN <= 1'b1;
    repeat (6) @(posedge clk);
    check("disarmed", 19'h0, {18'h0, selectArmed});
    sWrite(8'h3A);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    host.clockBits(8, 16'h005A);
    repeat (10) @(posedge clk);
    check("rx before arm", 19'h0, 19'(rxCount));
    host.deselect();
    sWrite(8'hC3);
    sRead();
    opRun(3'h1, 19'h12345, 19'h12000, 19'h12FFF, SEC_N);
    opRun(3'h2, 19'h5ABCD, 19'h50000, 19'h5FFFF, BLK_N);
    regionProtectBits <= 3'h1;
    opRefuse(3'h3);
    regionProtectBits <= 3'h0;
    invertProtectRegion <= 1'b1;
    opRefuse(3'h3);
    invertProtectRegion <= 1'b0;
    opRefuse(3'h6);
    opReq(3'h3, 19'h0);
    waitFlag(1, CHIP_N + 5);
    pageOld <= 8'hF0;
    pageNew <= 8'h3C;
    repeat (2) @(posedge clk);
    #1;
    check("merged", 19'h30, {11'h0, pageMerged});
    sGuard();
    sRestart();
    end_of_test();
  end
endmodule // testbench
